// ### verilog/tcc_defs.vh
/*
 * Constants of the timer and capture configuration block: register
 * indexes, field positions, reset values and timing counts.
 * Assumes it is included by bare name from the design files.
 */
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// ****************************************
// Register indexes (byte address = 4 * index)
// ****************************************
`define TCC_IDX_CTRL      6'h16
`define TCC_IDX_TIMERS    6'h17
`define TCC_IDX_WIDE      6'h18
`define TCC_IDX_CAP_A     6'h19
`define TCC_IDX_CAP_B     6'h1a

// ****************************************
// Control register fields and reset
// ****************************************
`define TCC_CTRL_RST      8'h00
`define TCC_CAP_B_MSB     7
`define TCC_CAP_B_LSB     6
`define TCC_CAP_A_MSB     5
`define TCC_CAP_A_LSB     4
`define TCC_JOIN_BIT      3
`define TCC_WIDE_SEL_BIT  2
`define TCC_B_SEL_BIT     1
`define TCC_A_SEL_BIT     0

// ****************************************
// Capture modes
// ****************************************
`define TCC_MODE_FALL     2'h0
`define TCC_MODE_RISE     2'h1
`define TCC_MODE_RISE4    2'h2
`define TCC_MODE_RISE16   2'h3
`define TCC_CNT_RISE4     4'h3
`define TCC_CNT_RISE16    4'hf

// ****************************************
// Timing and bus answers
// ****************************************
`define TCC_INST_DIV      4
`define TCC_INST_LAST     2'h3
`define TCC_RESP_OKAY     2'h0
`define TCC_RESP_DECERR   2'h3

`endif

// ### verilog/tcc_cap_sel.v
/*
 * One capture channel's event selector: picks falling, rising, every
 * fourth or every sixteenth rising edge of an already synchronised input.
 * Assumes level and level_d are the two last stages of a synchroniser.
 */
`timescale 1ns/1ps
`default_nettype none

`include "tcc_defs.vh"

module tcc_cap_sel (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       level,
    input  wire       level_d,
    input  wire [1:0] mode,
    input  wire       restart,
    output reg        event_ff
);
    reg  [3:0] cnt_ff;
    reg  [3:0] nxt_cnt;
    reg        nxt_event;
    wire       rise;
    wire       fall;

    assign rise = level & ~level_d;
    assign fall = ~level & level_d;

    always @* begin
        nxt_cnt   = cnt_ff;
        nxt_event = 1'b0;
        if (restart) begin
            // A control register write with lane 0 strobe set starts a fresh edge count
            nxt_cnt = 4'h0;
        end else begin
            case (mode)
                `TCC_MODE_FALL: nxt_event = fall;
                `TCC_MODE_RISE: nxt_event = rise;
                `TCC_MODE_RISE4: begin
                    if (rise) begin
                        nxt_event = (cnt_ff == `TCC_CNT_RISE4);
                        nxt_cnt   = (cnt_ff == `TCC_CNT_RISE4) ? 4'h0 : cnt_ff + 4'h1;
                    end
                end
                `TCC_MODE_RISE16: begin
                    if (rise) begin
                        nxt_event = (cnt_ff == `TCC_CNT_RISE16);
                        nxt_cnt   = cnt_ff + 4'h1;
                    end
                end
                default: nxt_event = 1'b0;
            endcase
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff   <= 4'h0;
            event_ff <= 1'b0;
        end else begin
            cnt_ff   <= nxt_cnt;
            event_ff <= nxt_event;
        end
    end
endmodule // tcc_cap_sel

`default_nettype wire

// ### verilog/tcc_top.v
/*
 * Timer and capture configuration block with an AXI4-Lite register slave,
 * two 8-bit timers that can join into one 16-bit timer, a 16-bit capture
 * time-base and two capture channels.
 * Assumes one clock, synchronous active-low reset, asynchronous pins.
 */
// Notes on behaviour
// - Channel B mode picks its capture edge
// - Channel A mode uses the same encoding
// - Join bit chains timer B onto timer A
// - Wide timer counts falling edges of own pin
// - Timer B counts falling edges of shared pin
// - Timer A counts falling edges of shared pin
// - Control register read/write, clears at reset
// - Internal clock is the clock divided by four
// - Capture latches the wide timer value
// - Joined timer follows timer A clock select
`timescale 1ns/1ps
`default_nettype none

`include "tcc_defs.vh"

module tcc_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        cap_a_pin,
    input  wire        cap_b_pin,
    input  wire        shared_ext_clk_pin,
    input  wire        wide_timer_ext_clk_pin
);
    // ****************************************
    // Declarations
    // ****************************************
    reg  [7:0]  ctrl_ff;
    reg  [5:0]  aw_idx_ff;
    reg  [31:0] wdata_ff;
    reg  [3:0]  wstrb_ff;
    reg         aw_got_ff;
    reg         w_got_ff;
    reg  [1:0]  div_ff;
    reg  [3:0]  pin_s1_ff;
    reg  [3:0]  pin_s2_ff;
    reg  [3:0]  pin_s3_ff;
    reg  [7:0]  timer_a_ff;
    reg  [7:0]  timer_b_ff;
    reg  [15:0] wide_timer_ff;
    reg  [15:0] cap_a_val_ff;
    reg  [15:0] cap_b_val_ff;
    reg  [31:0] nxt_rdata;
    reg  [1:0]  nxt_rresp;
    wire        aw_hs;
    wire        w_hs;
    wire        ar_hs;
    wire        aw_have;
    wire        w_have;
    wire        do_write;
    wire        nxt_bvalid;
    wire        ctrl_wr;
    wire        inst_tick;
    wire [3:0]  pin_fall;
    wire        tick_a;
    wire        tick_b;
    wire        tick_wide;
    wire [1:0]  cap_event;
    wire [1:0]  cap_mode [0:1];

    // ****************************************
    // Write channel
    // ****************************************
    // Address and data are taken in either order and held until both exist
    assign aw_hs      = s_axi_awvalid & s_axi_awready;
    assign w_hs       = s_axi_wvalid & s_axi_wready;
    assign aw_have    = aw_got_ff | aw_hs;
    assign w_have     = w_got_ff | w_hs;
    assign do_write   = aw_got_ff & w_got_ff;
    assign nxt_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);
    assign ctrl_wr    = do_write & (aw_idx_ff == `TCC_IDX_CTRL) & wstrb_ff[0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff     <= 1'b0;
            w_got_ff      <= 1'b0;
            aw_idx_ff     <= 6'h00;
            wdata_ff      <= 32'h0000_0000;
            wstrb_ff      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TCC_RESP_OKAY;
            ctrl_ff       <= `TCC_CTRL_RST;
        end else begin
            aw_got_ff     <= aw_have & ~do_write;
            w_got_ff      <= w_have & ~do_write;
            s_axi_awready <= ~(aw_have & ~do_write) & ~nxt_bvalid & ~do_write;
            s_axi_wready  <= ~(w_have & ~do_write) & ~nxt_bvalid & ~do_write;
            s_axi_bvalid  <= nxt_bvalid;
            if (aw_hs) begin
                aw_idx_ff <= s_axi_awaddr[7:2];
            end
            if (w_hs) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                // Status registers accept writes silently; holes answer DECERR
                s_axi_bresp <= (aw_idx_ff >= `TCC_IDX_CTRL && aw_idx_ff <= `TCC_IDX_CAP_B)
                               ? `TCC_RESP_OKAY : `TCC_RESP_DECERR;
            end
            if (ctrl_wr) begin
                ctrl_ff <= wdata_ff[7:0];
            end
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    assign ar_hs = s_axi_arvalid & s_axi_arready;

    always @* begin
        nxt_rresp = `TCC_RESP_OKAY;
        case (s_axi_araddr[7:2])
            `TCC_IDX_CTRL:   nxt_rdata = {24'h00_0000, ctrl_ff};
            `TCC_IDX_TIMERS: nxt_rdata = {16'h0000, timer_b_ff, timer_a_ff};
            `TCC_IDX_WIDE:   nxt_rdata = {16'h0000, wide_timer_ff};
            `TCC_IDX_CAP_A:  nxt_rdata = {16'h0000, cap_a_val_ff};
            `TCC_IDX_CAP_B:  nxt_rdata = {16'h0000, cap_b_val_ff};
            default: begin
                nxt_rdata = 32'h0000_0000;
                nxt_rresp = `TCC_RESP_DECERR;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `TCC_RESP_OKAY;
        end else begin
            s_axi_rvalid  <= ar_hs | (s_axi_rvalid & ~s_axi_rready);
            s_axi_arready <= ~(ar_hs | (s_axi_rvalid & ~s_axi_rready));
            if (ar_hs) begin
                s_axi_rdata <= nxt_rdata;
                s_axi_rresp <= nxt_rresp;
            end
        end
    end

    // ****************************************
    // Pin synchronisers and clock sources
    // ****************************************
    // Pins: 0 cap A, 1 cap B, 2 shared clock, 3 wide timer clock
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_ff <= 4'h0;
            pin_s2_ff <= 4'h0;
            pin_s3_ff <= 4'h0;
            div_ff    <= 2'h0;
        end else begin
            pin_s1_ff <= {wide_timer_ext_clk_pin, shared_ext_clk_pin, cap_b_pin, cap_a_pin};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            div_ff    <= div_ff + 2'h1;
        end
    end

    assign pin_fall  = ~pin_s2_ff & pin_s3_ff;
    // Instruction clock is one tick in four system clocks
    assign inst_tick = (div_ff == `TCC_INST_LAST);
    assign tick_a    = ctrl_ff[`TCC_A_SEL_BIT] ? pin_fall[2] : inst_tick;
    // Joined: timer B only carries from timer A, its own select is ignored
    assign tick_b    = ctrl_ff[`TCC_JOIN_BIT] ? (tick_a & (timer_a_ff == 8'hff))
                     : (ctrl_ff[`TCC_B_SEL_BIT] ? pin_fall[2] : inst_tick);
    assign tick_wide = ctrl_ff[`TCC_WIDE_SEL_BIT] ? pin_fall[3] : inst_tick;

    // ****************************************
    // Timers and captures
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            timer_a_ff    <= 8'h00;
            timer_b_ff    <= 8'h00;
            wide_timer_ff <= 16'h0000;
            cap_a_val_ff  <= 16'h0000;
            cap_b_val_ff  <= 16'h0000;
        end else begin
            if (tick_a) begin
                timer_a_ff <= timer_a_ff + 8'h01;
            end
            if (tick_b) begin
                timer_b_ff <= timer_b_ff + 8'h01;
            end
            if (tick_wide) begin
                wide_timer_ff <= wide_timer_ff + 16'h0001;
            end
            if (cap_event[0]) begin
                cap_a_val_ff <= wide_timer_ff;
            end
            if (cap_event[1]) begin
                cap_b_val_ff <= wide_timer_ff;
            end
        end
    end

    assign cap_mode[0] = ctrl_ff[`TCC_CAP_A_MSB:`TCC_CAP_A_LSB];
    assign cap_mode[1] = ctrl_ff[`TCC_CAP_B_MSB:`TCC_CAP_B_LSB];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_cap
            tcc_cap_sel u_sel (
                .aclk     (aclk),
                .aresetn  (aresetn),
                .level    (pin_s2_ff[ch]),
                .level_d  (pin_s3_ff[ch]),
                .mode     (cap_mode[ch]),
                .restart  (ctrl_wr),
                .event_ff (cap_event[ch])
            );
        end
    endgenerate
endmodule // tcc_top

`default_nettype wire

// ### verif/tcc_pin_model.sv
/* Pin model: capture inputs and timer clock pins.
   Assumes the bench calls its tasks; pins change after aclk edges. */
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
    input  wire logic aclk,
    output var  logic cap_a,
    output var  logic cap_b,
    output var  logic shr_clk,
    output var  logic wide_clk
);
    // ****
    // Pin drivers
    // ****
    initial begin
        cap_a = 1'b0;
        cap_b = 1'b0;
        shr_clk = 1'b1;
        wide_clk = 1'b1;
    end
    // Both inputs move together; 8 cycles covers the synchroniser
    task automatic cap_set(input logic v);
        @(posedge aclk);
        cap_a <= v;
        cap_b <= v;
        repeat (8) @(posedge aclk);
    endtask
    // Low pulses give falling edges; clocks idle high between them
    task automatic pulses(input int ns, input int nw);
        for (int i = 0; i < ns || i < nw; i++) begin
            @(posedge aclk);
            shr_clk <= (i < ns) ? 1'b0 : 1'b1;
            wide_clk <= (i < nw) ? 1'b0 : 1'b1;
            repeat (4) @(posedge aclk);
            shr_clk <= 1'b1;
            wide_clk <= 1'b1;
            repeat (4) @(posedge aclk);
        end
    endtask
endmodule // tcc_pin_model
`default_nettype wire

// ### verif/tcc_checker.sv
/* Bus-port checker of tcc_top.
   Assumes it is bound into tcc_top, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module tcc_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    // ****
    // Assertions
    // ****
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire       aw_t = s_axi_awvalid & s_axi_awready;
    wire       w_t  = s_axi_wvalid & s_axi_wready;
    wire       ar_t = s_axi_arvalid & s_axi_arready;
    wire [5:0] idx  = s_axi_araddr[7:2];
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    b_lat_a: assert property (aw_t && w_t |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two edges on");
    r_lat_a: assert property (ar_t |=> s_axi_rvalid) else $error("read answer late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while pending");
    w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while pending");
    r_decerr_a: assert property (ar_t && (idx < 6'h16 || idx > 6'h1a) |=>
        s_axi_rresp == 2'h3) else $error("unmapped read not refused");
    ctrl_rd_a: assert property (ar_t && idx == 6'h16 |=>
        s_axi_rresp == 2'h0 && s_axi_rdata[31:8] == 24'h0) else $error("control read wrong");
    cover property (aw_t && w_t);
    cover property (ar_t && idx == 6'h19);
    cover property (ar_t && idx > 6'h1a);
endmodule // tcc_checker
bind tcc_top tcc_checker u_tcc_checker (.aclk, .aresetn, .s_axi_araddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ### verif/tcc_top_tb.sv
/* Bench of tcc_top: registers, timer clocks, join and capture modes.
   Assumes tcc_pin_model on the pins and tcc_checker bound. */
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"
module tcc_top_tb;
    // ****
    // Signals and instances
    // ****
    localparam logic [7:0] A_CTRL = {`TCC_IDX_CTRL, 2'h0};
    localparam logic [7:0] A_TMR  = {`TCC_IDX_TIMERS, 2'h0};
    localparam logic [7:0] A_WIDE = {`TCC_IDX_WIDE, 2'h0};
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [2:0]  prot;
    wire         awready, wready, bvalid, arready, rvalid, cap_a, cap_b, shr_clk, wide_clk;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    int          fails, cmp_count;
    tcc_top u_tcc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(prot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(prot), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cap_a_pin(cap_a), .cap_b_pin(cap_b),
        .shared_ext_clk_pin(shr_clk), .wide_timer_ext_clk_pin(wide_clk));
    tcc_pin_model u_tcc_pin_model (.aclk(aclk), .cap_a(cap_a), .cap_b(cap_b),
        .shr_clk(shr_clk), .wide_clk(wide_clk));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (fails == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Valids drop once taken; bready held until the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        r = bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
    task automatic rv(input logic [7:0] a, output logic [31:0] d);
        logic [1:0] r;
        rd(a, d, r);
        chk({30'h0, r}, {30'h0, `TCC_RESP_OKAY});
    endtask
    task automatic wc(input logic [31:0] d);
        logic [1:0] r;
        wr(A_CTRL, d, r);
        chk({30'h0, r}, {30'h0, `TCC_RESP_OKAY});
    endtask
    // Takes of the two reads are exactly 40 clocks apart
    task automatic gap(input logic [7:0] a, output logic [31:0] d0, output logic [31:0] d1);
        rv(a, d0);
        repeat (37) @(posedge aclk);
        rv(a, d1);
    endtask
    task automatic caps(output logic [31:0] a, output logic [31:0] b);
        rv({`TCC_IDX_CAP_A, 2'h0}, a);
        rv({`TCC_IDX_CAP_B, 2'h0}, b);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0]  r;
        rv(A_CTRL, d);
        chk(d, {24'h0, `TCC_CTRL_RST});
        wc(32'hffff_ffa5);
        rv(A_CTRL, d);
        chk(d, 32'ha5);
        wr(A_TMR, 32'hff, r);
        rv(A_CTRL, d);
        chk(d, 32'ha5);
        // Lane 0 strobe low: control byte must keep its value; protection is ignored
        wstrb <= 4'he;
        prot  <= 3'h5;
        wc(32'h0);
        rv(A_CTRL, d);
        chk(d, 32'ha5);
        wstrb <= 4'hf;
        prot  <= 3'h0;
        wr(8'hfc, 32'h0, r);
        chk({30'h0, r}, {30'h0, `TCC_RESP_DECERR});
        rd(8'hfc, d, r);
        chk({30'h0, r}, {30'h0, `TCC_RESP_DECERR});
    endtask
    task automatic t_timers;
        logic [31:0] d0, d1, w0, w1;
        wc(32'h0);
        gap(A_TMR, d0, d1);
        chk(d1, {16'h0, d0[15:8] + 8'ha, d0[7:0] + 8'ha});
        gap(A_WIDE, w0, w1);
        chk(w1, {16'h0, w0[15:0] + 16'ha});
        wc(32'h7);
        rv(A_TMR, d0);
        rv(A_WIDE, w0);
        u_tcc_pin_model.pulses(5, 3);
        rv(A_TMR, d1);
        rv(A_WIDE, w1);
        chk(d1, {16'h0, d0[15:8] + 8'h5, d0[7:0] + 8'h5});
        chk(w1, {16'h0, w0[15:0] + 16'h3});
        wc(32'h8);
        gap(A_TMR, d0, d1);
        chk(d1, {16'h0, d0[15:0] + 16'ha});
        wc(32'hb);
        rv(A_TMR, d0);
        u_tcc_pin_model.pulses(5, 0);
        rv(A_TMR, d1);
        chk(d1, {16'h0, d0[15:0] + 16'h5});
    endtask
    task automatic cap_run(input logic [1:0] m);
        logic [31:0] a0, b0, a1, b1, w;
        int          n;
        n = (m == `TCC_MODE_RISE4) ? 5 : (m == `TCC_MODE_RISE16) ? 15 : 0;
        wc({24'h0, m, m, 4'h0});
        caps(a0, b0);
        for (int i = 0; i < n; i++) begin
            if (m == `TCC_MODE_RISE4 && i == 2) wc({24'h0, m, m, 4'h0});
            u_tcc_pin_model.cap_set(1'b1);
            u_tcc_pin_model.cap_set(1'b0);
        end
        caps(a1, b1);
        chk({a1 !== a0, b1 !== b0}, 32'h0);
        u_tcc_pin_model.cap_set(1'b1);
        caps(a1, b1);
        chk({a1 !== a0, b1 !== b0}, {30'h0, {2{m != `TCC_MODE_FALL}}});
        rv(A_WIDE, w);
        if (m != `TCC_MODE_FALL) chk(w[15:0] - a1[15:0] < 16'h8, 32'h1);
        u_tcc_pin_model.cap_set(1'b0);
        caps(a0, b0);
        chk({a0 !== a1, b0 !== b1}, {30'h0, {2{m == `TCC_MODE_FALL}}});
    endtask
    // ****
    // Main sequence and watchdog
    // ****
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hf;
        prot = 3'h0;
        fails = 0;
        cmp_count = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_timers;
        for (int m = 0; m < 4; m++) cap_run(m[1:0]);
        close_out;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        close_out;
    end
endmodule // tcc_top_tb
`default_nettype wire
